/* File: core/ldc_pkg.sv */
// Package: constants, register map and modes of the cascade driver
package ldc_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CHANNELS = 80;
  localparam int unsigned HALF_CHANNELS = 40;
  localparam int unsigned NIBBLE_W = 4;
  localparam int unsigned COUNT_W = 7;

  localparam logic [COUNT_W-1:0] LOADS_PARALLEL = 7'd20;
  localparam logic [COUNT_W-1:0] LOADS_SERIAL   = 7'd80;

  localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_DATA0  = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_DATA1  = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_DATA2  = 8'h10;

  localparam int unsigned CTRL_COMMON_BIT = 0;
  localparam int unsigned CTRL_AMS_BIT    = 1;
  localparam int unsigned CTRL_SHL_BIT    = 2;
  localparam int unsigned CTRL_FREEZE_BIT = 3;
  localparam int unsigned CTRL_W          = 4;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h0;

  localparam int unsigned STAT_ENABLED_BIT = 0;
  localparam int unsigned STAT_PASSED_BIT  = 1;
  localparam int unsigned STAT_FULL_BIT    = 2;
  localparam int unsigned STAT_COUNT_LSB   = 8;

  localparam int unsigned BUF_DEPTH = 2;

  typedef enum logic [1:0] {
    MODE_SEG_PARALLEL,
    MODE_SEG_SERIAL,
    MODE_COM_SINGLE,
    MODE_COM_DUAL
  } ldc_mode_e;

  function automatic ldc_mode_e ldc_decode_mode(input logic common_sel, input logic application_mode_select);
    ldc_mode_e m;
    m = MODE_SEG_PARALLEL;
    if (!common_sel && application_mode_select) m = MODE_SEG_SERIAL;
    if (common_sel && !application_mode_select) m = MODE_COM_SINGLE;
    if (common_sel && application_mode_select) m = MODE_COM_DUAL;
    return m;
  endfunction
endpackage

/* File: core/ldc_buf.sv */
// Small valid/ready buffer between the data pins and the segment shift register
`timescale 1ns/1ps
`default_nettype none
module ldc_buf #(
  parameter int unsigned WIDTH = 4,
  parameter int unsigned DEPTH = 2
) (
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CNT_W = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg;
  logic [PTR_W-1:0] rd_ptr_reg;
  logic [CNT_W-1:0] count_reg;
  logic             push;
  logic             pop;

  assign in_ready  = (count_reg != CNT_W'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data  = mem_reg[rd_ptr_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  function automatic logic [PTR_W-1:0] bump(input logic [PTR_W-1:0] p);
    return (p == PTR_W'(DEPTH - 1)) ? '0 : p + PTR_W'(1);
  endfunction

  always_ff @(posedge clock) begin
    if (push) mem_reg[wr_ptr_reg] <= in_data;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) wr_ptr_reg <= bump(wr_ptr_reg);
      if (pop) rd_ptr_reg <= bump(rd_ptr_reg);
      if (push && !pop) count_reg <= count_reg + CNT_W'(1);
      else if (pop && !push) count_reg <= count_reg - CNT_W'(1);
    end
  end
endmodule // ldc_buf
`default_nettype wire

/* File: core/ldc_top.sv */
// Cascade enable chain and data routing of an 80-output LCD row/column driver
// How it works
// - With shift direction low the right enable pin is the enable input, the left one the output, and work only while input is low.
// - With shift direction high the left enable pin is the enable input, the right one the output, and work only while it is low.
// - In common mode the enable gating is off, the enable pins are not driven and shifting ignores them.
// - A segment driver passes its enable on after 20 loads in parallel mode or 80 in serial mode.
// - Dual common mode takes left and middle pins as inputs with direction low, right and middle with it high, output at the far end.
// - Dual common mode splits the 80 outputs into two 40-channel chains shifted together on the latch clock.
// - Common select and mode select pick parallel segment, serial segment, single common or dual common mode.
// - Single common mode shifts one bit along the 80-bit chain per latch clock in the chosen direction.
// - A high latch clock restarts the enable chain for the next line.
//
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module ldc_top
  import ldc_pkg::*;
#(
  parameter int unsigned BUF_WIDTH = NIBBLE_W,
  parameter int unsigned BUF_DEPTH_P = BUF_DEPTH
) (
  input  wire logic                clock,
  input  wire logic                reset,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [ADDR_W-1:0]   paddr,
  input  wire logic [DATA_W-1:0]   pwdata,
  output logic      [DATA_W-1:0]   prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                line_latch_clock,
  input  wire logic                data_shift_clock,
  input  wire logic                display_blank_n,
  input  wire logic                data_pin_one_serial_in,
  input  wire logic                left_data_pin_in,
  output logic                     left_data_pin_out,
  output logic                     left_data_pin_oe,
  input  wire logic                middle_data_pin,
  input  wire logic                right_data_pin_in,
  output logic                     right_data_pin_out,
  output logic                     right_data_pin_oe,
  input  wire logic                left_chain_enable_in,
  output logic                     left_chain_enable_out,
  output logic                     left_chain_enable_oe,
  input  wire logic                right_chain_enable_in,
  output logic                     right_chain_enable_out,
  output logic                     right_chain_enable_oe,
  output logic      [CHANNELS-1:0] driver_data,
  output logic                     driver_blank
);
  logic [CTRL_W-1:0]   ctrl_reg;
  logic                shift_clk_prev_reg;
  logic                latch_clk_prev_reg;
  logic [COUNT_W-1:0]  load_count_reg;
  logic                passed_reg;
  logic [CHANNELS-1:0] seg_shift_reg;
  logic [CHANNELS-1:0] seg_latch_reg;
  logic [CHANNELS-1:0] com_chain_reg;
  logic                latch_pending_reg;

  ldc_mode_e           mode;
  logic                serial_mode;
  logic                common_sel;
  logic                shl;
  logic                enable_in_n;
  logic                chip_enabled;
  logic                shift_fall;
  logic                latch_fall;
  logic [COUNT_W-1:0]  loads_needed;
  logic [NIBBLE_W-1:0] pin_word;
  logic                buf_in_ready;
  logic                buf_out_valid;
  logic                buf_out_ready;
  logic [NIBBLE_W-1:0] buf_out_data;
  logic                load_take;
  logic                apb_write;
  logic [DATA_W-1:0]   read_word;
  logic                addr_hit;

  assign common_sel = ctrl_reg[CTRL_COMMON_BIT];
  assign shl        = ctrl_reg[CTRL_SHL_BIT];
  assign mode       = ldc_decode_mode(common_sel, ctrl_reg[CTRL_AMS_BIT]);

  // Serial and parallel segment modes differ only in load width and load count
  assign serial_mode = (mode == MODE_SEG_SERIAL);

  // Enable input follows the shift direction
  assign enable_in_n  = shl ? left_chain_enable_in : right_chain_enable_in;
  assign chip_enabled = !common_sel && !enable_in_n && !passed_reg && !line_latch_clock;

  assign shift_fall = shift_clk_prev_reg && !data_shift_clock;
  assign latch_fall = latch_clk_prev_reg && !line_latch_clock;

  assign loads_needed = serial_mode ? LOADS_SERIAL : LOADS_PARALLEL;
  assign pin_word     = serial_mode ?
                        {{(NIBBLE_W-1){1'b0}}, data_pin_one_serial_in} :
                        {right_data_pin_in, middle_data_pin, left_data_pin_in, data_pin_one_serial_in};

  // A load arriving while the buffer is full is refused and not counted
  assign load_take     = shift_fall && chip_enabled && buf_in_ready;
  // A waiting latch must not stall the drain it waits for
  assign buf_out_ready = !ctrl_reg[CTRL_FREEZE_BIT];

  ldc_buf #(
    .WIDTH (BUF_WIDTH),
    .DEPTH (BUF_DEPTH_P)
  ) u_buf (
    .clock     (clock),
    .reset     (reset),
    .in_valid  (load_take),
    .in_ready  (buf_in_ready),
    .in_data   (pin_word),
    .out_valid (buf_out_valid),
    .out_ready (buf_out_ready),
    .out_data  (buf_out_data)
  );

  // Edge detectors start at the idle low level, so reset makes no false edge
  always_ff @(posedge clock) begin
    if (reset) begin
      shift_clk_prev_reg <= 1'b0;
    end else begin
      shift_clk_prev_reg <= data_shift_clock;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      latch_clk_prev_reg <= 1'b0;
    end else begin
      latch_clk_prev_reg <= line_latch_clock;
    end
  end

  // Power-down chain: count loads, hand the enable on when full
  always_ff @(posedge clock) begin
    if (reset || line_latch_clock || common_sel) begin
      load_count_reg <= '0;
    end else if (load_take) begin
      load_count_reg <= load_count_reg + COUNT_W'(1);
    end
  end

  // Passed holds until the next line, which also stops the count from wrapping
  always_ff @(posedge clock) begin
    if (reset || line_latch_clock || common_sel) begin
      passed_reg <= 1'b0;
    end else if (load_take && (load_count_reg + COUNT_W'(1) == loads_needed)) begin
      passed_reg <= 1'b1;
    end
  end

  // Segment shift register fed from the buffer
  always_ff @(posedge clock) begin
    if (reset) begin
      seg_shift_reg <= '0;
    end else if (buf_out_valid && buf_out_ready) begin
      if (serial_mode) begin
        seg_shift_reg <= shl ? {buf_out_data[0], seg_shift_reg[CHANNELS-1:1]} :
                               {seg_shift_reg[CHANNELS-2:0], buf_out_data[0]};
      end else begin
        seg_shift_reg <= shl ? {buf_out_data, seg_shift_reg[CHANNELS-1:NIBBLE_W]} :
                               {seg_shift_reg[CHANNELS-NIBBLE_W-1:0], buf_out_data};
      end
    end
  end

  // Latch waits for the buffer to drain so no queued word misses its line
  always_ff @(posedge clock) begin
    if (reset) begin
      latch_pending_reg <= 1'b0;
    end else begin
      if (latch_pending_reg && !buf_out_valid) latch_pending_reg <= 1'b0;
      // A new fall in the same cycle wins over the clear
      if (latch_fall && !common_sel) latch_pending_reg <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      seg_latch_reg <= '0;
    end else if (latch_pending_reg && !buf_out_valid) begin
      seg_latch_reg <= seg_shift_reg;
    end
  end

  // Common chain shifts on the latch clock, enable pins ignored
  always_ff @(posedge clock) begin
    if (reset) begin
      com_chain_reg <= '0;
    end else if (latch_fall && common_sel) begin
      unique case (mode)
        MODE_COM_DUAL: begin
          if (!shl) begin
            com_chain_reg <= {com_chain_reg[CHANNELS-2:HALF_CHANNELS], middle_data_pin,
                              com_chain_reg[HALF_CHANNELS-2:0], left_data_pin_in};
          end else begin
            com_chain_reg <= {right_data_pin_in, com_chain_reg[CHANNELS-1:HALF_CHANNELS+1],
                              middle_data_pin, com_chain_reg[HALF_CHANNELS-1:1]};
          end
        end
        default: begin
          com_chain_reg <= shl ? {right_data_pin_in, com_chain_reg[CHANNELS-1:1]} :
                                 {com_chain_reg[CHANNELS-2:0], left_data_pin_in};
        end
      endcase
    end
  end

  // Enable pins: only the output end of the chain is driven, and only in segment mode
  always_ff @(posedge clock) begin
    if (reset) begin
      left_chain_enable_out  <= 1'b1;
      left_chain_enable_oe   <= 1'b0;
      right_chain_enable_out <= 1'b1;
      right_chain_enable_oe  <= 1'b0;
    end else begin
      left_chain_enable_out  <= !passed_reg;
      right_chain_enable_out <= !passed_reg;
      left_chain_enable_oe   <= !common_sel && !shl;
      right_chain_enable_oe  <= !common_sel && shl;
    end
  end

  // Data pins follow the far end of the common chain one cycle late
  always_ff @(posedge clock) begin
    if (reset) begin
      left_data_pin_out  <= 1'b0;
      left_data_pin_oe   <= 1'b0;
      right_data_pin_out <= 1'b0;
      right_data_pin_oe  <= 1'b0;
    end else begin
      left_data_pin_out  <= com_chain_reg[0];
      right_data_pin_out <= com_chain_reg[CHANNELS-1];
      left_data_pin_oe   <= common_sel && shl;
      right_data_pin_oe  <= common_sel && !shl;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      driver_data <= '0;
    end else begin
      driver_data <= common_sel ? com_chain_reg : seg_latch_reg;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      driver_blank <= 1'b1;
    end else begin
      driver_blank <= !display_blank_n;
    end
  end

  // APB slave: answer one cycle into the access phase, in its second cycle
  assign apb_write = psel && penable && pready && pwrite;

  always_comb begin
    read_word = '0;
    addr_hit  = 1'b1;
    unique case (paddr)
      OFS_CTRL: read_word[CTRL_W-1:0] = ctrl_reg;
      OFS_STATUS: begin
        read_word[STAT_ENABLED_BIT] = chip_enabled;
        read_word[STAT_PASSED_BIT]  = passed_reg;
        read_word[STAT_FULL_BIT]    = !buf_in_ready;
        read_word[STAT_COUNT_LSB +: COUNT_W] = load_count_reg;
      end
      OFS_DATA0: read_word = driver_data[31:0];
      OFS_DATA1: read_word = driver_data[63:32];
      OFS_DATA2: read_word[CHANNELS-65:0] = driver_data[CHANNELS-1:64];
      default: addr_hit = 1'b0;
    endcase
  end

  // Registered answer costs one wait state but keeps the bus outputs glitch free
  always_ff @(posedge clock) begin
    if (reset) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      pslverr <= 1'b0;
      prdata  <= '0;
    end else if (psel && penable && !pready) begin
      pslverr <= !addr_hit;
      prdata  <= pwrite ? '0 : read_word;
    end else begin
      pslverr <= 1'b0;
      prdata  <= '0;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      ctrl_reg <= CTRL_RESET;
    end else if (apb_write && paddr == OFS_CTRL) begin
      ctrl_reg <= pwdata[CTRL_W-1:0];
    end
  end
endmodule // ldc_top
`default_nettype wire

/* File: bench/ldc_top_props.sv */
// Checker: port-level properties of the cascade driver block
`timescale 1ns/1ps
`default_nettype none
module ldc_top_props
  import ldc_pkg::*;
(
  input wire logic              clock,
  input wire logic              reset,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              line_latch_clock,
  input wire logic              left_chain_enable_out,
  input wire logic              left_chain_enable_oe,
  input wire logic              right_chain_enable_out,
  input wire logic              right_chain_enable_oe,
  input wire logic              left_data_pin_oe,
  input wire logic              right_data_pin_oe
);
  logic [CTRL_W-1:0] ctrl_reg;
  logic [1:0]        age_reg;
  logic              settled;
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // Shadow of the mode register; pin checks wait a few cycles so registered pins can follow a write
  always_ff @(posedge clock) begin
    if (reset) begin
      ctrl_reg <= CTRL_RESET;
      age_reg  <= 2'd0;
    end else if (psel && penable && pready && pwrite && paddr == OFS_CTRL) begin
      ctrl_reg <= pwdata[CTRL_W-1:0];
      age_reg  <= 2'd0;
    end else if (age_reg != 2'd3) begin
      age_reg <= age_reg + 2'd1;
    end
  end
  assign settled = (age_reg == 2'd3);
  a_ready_after_access: assert property (psel && $rose(penable) |=> pready)
    else $error("pready late after access phase");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_err_on_unmapped: assert property (pready |-> pslverr == (paddr[1:0] != 2'b00 || paddr > OFS_DATA2))
    else $error("pslverr does not match address map");
  a_common_pins_free: assert property (
    settled && ctrl_reg[0] |-> !left_chain_enable_oe && !right_chain_enable_oe)
    else $error("enable pin driven in common mode");
  a_seg_right_in: assert property (
    settled && !ctrl_reg[0] && !ctrl_reg[2] |-> !right_chain_enable_oe && !left_data_pin_oe && !right_data_pin_oe)
    else $error("right enable pin not an input");
  a_seg_left_in: assert property (
    settled && !ctrl_reg[0] && ctrl_reg[2] |-> !left_chain_enable_oe)
    else $error("left enable pin not an input");
  a_com_out_pin: assert property (
    settled && ctrl_reg[0] |-> left_data_pin_oe == ctrl_reg[2] && right_data_pin_oe == !ctrl_reg[2])
    else $error("wrong common output pin");
  a_latch_restart: assert property (
    settled && !ctrl_reg[0] && $rose(line_latch_clock)
      |-> ##[1:3] (ctrl_reg[2] ? right_chain_enable_out : left_chain_enable_out))
    else $error("enable chain not restarted by latch");
endmodule // ldc_top_props
bind ldc_top ldc_top_props u_props (.clock(clock), .reset(reset), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .line_latch_clock(line_latch_clock), .left_chain_enable_out(left_chain_enable_out),
  .left_chain_enable_oe(left_chain_enable_oe), .right_chain_enable_out(right_chain_enable_out),
  .right_chain_enable_oe(right_chain_enable_oe), .left_data_pin_oe(left_data_pin_oe),
  .right_data_pin_oe(right_data_pin_oe));
`default_nettype wire

/* File: bench/ldc_ctrl_model.sv */
// Timing controller model: shift clock, latch clock and data pins
`timescale 1ns/1ps
`default_nettype none
module ldc_ctrl_model (
  input  wire logic       clock,
  output logic            shift_clk,
  output logic            latch_clk,
  output logic      [3:0] pins
);
  initial begin
    shift_clk = 1'b0;
    latch_clk = 1'b0;
    pins = 4'h0;
  end
  // Data held past the fall, then inverted so stale values never pass as fresh
  task automatic load(input logic [3:0] d);
    @(posedge clock) begin
      shift_clk <= 1'b1;
      pins <= d;
    end
    @(posedge clock) shift_clk <= 1'b0;
    repeat (2) @(posedge clock);
    pins <= ~d;
  endtask
  // One latch pulse shifts both halves at once in dual mode
  task automatic latch(input logic [3:0] d);
    @(posedge clock) begin
      latch_clk <= 1'b1;
      pins <= d;
    end
    @(posedge clock) latch_clk <= 1'b0;
    repeat (3) @(posedge clock);
    pins <= ~d;
  endtask
endmodule // ldc_ctrl_model
`default_nettype wire

/* File: bench/tb_ldc_top.sv */
// Testbench of the cascade enable chain and data routing block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin mismatches++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_ldc_top;
  import ldc_pkg::*;
  typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] q; logic e;} ldc_row_s;
  localparam ldc_row_s ROWS [6] = '{'{1'b0, 8'h00, 32'h0, 32'h0, 1'b0},
    '{1'b1, 8'h00, 32'hffff_fff6, 32'h0, 1'b0}, '{1'b0, 8'h00, 32'h0, 32'h6, 1'b0},
    '{1'b1, 8'h40, 32'hffff_ffff, 32'h0, 1'b1}, '{1'b0, 8'h1c, 32'h0, 32'h0, 1'b1},
    '{1'b0, 8'h00, 32'h0, 32'h6, 1'b0}};
  logic clock, reset, psel, penable, pwrite, pready, pslverr, en_l, en_r, er;
  logic lo, loe, ro, roe, elo, eloe, ero, eroe, sclk, lclk, blank, blank_n;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pins;
  logic [CHANNELS-1:0] drv, exp;
  int mismatches, checks;
  // Each shared pin carries whoever drives it
  wire logic l_pin = loe ? lo : pins[1];
  wire logic r_pin = roe ? ro : pins[3];
  wire logic l_en = eloe ? elo : en_l;
  wire logic r_en = eroe ? ero : en_r;
  ldc_ctrl_model model (.clock(clock), .shift_clk(sclk), .latch_clk(lclk), .pins(pins));
  ldc_top dut (.clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .line_latch_clock(lclk), .data_shift_clock(sclk), .display_blank_n(blank_n),
    .data_pin_one_serial_in(pins[0]), .left_data_pin_in(l_pin), .left_data_pin_out(lo),
    .left_data_pin_oe(loe), .middle_data_pin(pins[2]), .right_data_pin_in(r_pin),
    .right_data_pin_out(ro), .right_data_pin_oe(roe), .left_chain_enable_in(l_en),
    .left_chain_enable_out(elo), .left_chain_enable_oe(eloe), .right_chain_enable_in(r_en),
    .right_chain_enable_out(ero), .right_chain_enable_oe(eroe), .driver_data(drv), .driver_blank(blank));
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int n;
    n = 0;
    @(posedge clock) begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
    end
    @(posedge clock) penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      mismatches++;
      report_and_stop();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  initial begin
    repeat (60000) @(posedge clock);
    mismatches++;
    report_and_stop();
  end
  initial begin
    reset = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    en_l = 1'b1; en_r = 1'b0; mismatches = 0; checks = 0; exp = '0;
    blank_n = 1'b1;
    repeat (6) @(posedge clock);
    @(negedge clock) `CHK({elo, ero, eloe, eroe, drv}, {4'hc, 80'h0})
    @(posedge clock) reset <= 1'b0;
    foreach (ROWS[i]) begin
      apb(ROWS[i].w, ROWS[i].a, ROWS[i].d, rd, er);
      `CHK(er, ROWS[i].e)
      if (!ROWS[i].w) `CHK(rd, ROWS[i].q)
    end
    apb(1'b1, OFS_CTRL, 32'h0, rd, er);
    for (int i = 0; i < 20; i++) begin
      model.load(4'(i) ^ 4'h5);
      exp = {exp[CHANNELS-5:0], 4'(i) ^ 4'h5};
      repeat (2) @(negedge clock);
      if (i >= 18) `CHK(elo, i != 19)
    end
    model.latch(4'h0);
    repeat (2) @(negedge clock);
    `CHK(drv, exp)
    `CHK(elo, 1'b1)
    @(posedge clock) en_r <= 1'b1;
    for (int i = 0; i < 4; i++) model.load(4'hf);
    model.latch(4'h0);
    repeat (2) @(negedge clock);
    `CHK(drv, exp)
    apb(1'b1, OFS_CTRL, 32'h6, rd, er);
    @(posedge clock) en_l <= 1'b0;
    for (int i = 0; i < 80; i++) begin
      model.load({3'h0, i[0] ^ i[2]});
      exp = {i[0] ^ i[2], exp[CHANNELS-1:1]};
      repeat (2) @(negedge clock);
      if (i >= 78) `CHK(ero, i != 79)
    end
    model.latch(4'h0);
    repeat (2) @(negedge clock);
    `CHK(drv, exp)
    apb(1'b1, OFS_CTRL, 32'h1, rd, er);
    @(posedge clock) en_l <= 1'b1;
    for (int i = 0; i < 80; i++) begin
      model.latch({2'h0, i[1] ^ i[4], 1'b0});
      exp = {exp[CHANNELS-2:0], i[1] ^ i[4]};
    end
    repeat (2) @(negedge clock);
    `CHK(drv, exp)
    `CHK(ro, exp[CHANNELS-1])
    apb(1'b1, OFS_CTRL, 32'h7, rd, er);
    for (int i = 0; i < 40; i++) begin
      model.latch({i[0], i[1] ^ i[0], 2'h0});
      exp = {i[0], exp[79:41], i[1] ^ i[0], exp[39:1]};
    end
    repeat (2) @(negedge clock);
    `CHK(drv, exp)
    `CHK(lo, exp[0])
    apb(1'b0, OFS_DATA2, 32'h0, rd, er);
    `CHK(rd, {16'h0, exp[79:64]})
    @(posedge clock) blank_n <= 1'b0;
    repeat (2) @(negedge clock);
    `CHK(blank, 1'b1)
    // Reset in mid-run must bring the enable pins, driver data and blank back to their idle state
    @(posedge clock) reset <= 1'b1;
    repeat (3) @(posedge clock);
    @(negedge clock) `CHK({elo, ero, eloe, eroe, drv, blank}, {4'hc, 80'h0, 1'b1})
    @(posedge clock) begin
      reset <= 1'b0;
      blank_n <= 1'b1;
    end
    apb(1'b0, OFS_CTRL, 32'h0, rd, er);
    `CHK(rd, 32'h0)
    repeat (2) @(negedge clock);
    `CHK(blank, 1'b0)
    report_and_stop();
  end
endmodule // tb_ldc_top
`default_nettype wire
